// ### rtl/rss_pkg.sv
// package: register map, status bit layout and reset values for the ramp and switch status block
// Functional notes
// R1 - bit 13 mirrors the live stall detect level when stall detection is configured
// R2 - software should enable halt on stall, polling bit 13 can miss stalls
// R3 - bit 12 latches an automatic ramp reversal, cleared by reading
// R4 - bit 11 is high while the standstill delay runs after a stop
// R5 - bit 10 is high when current speed is zero
// R6 - bit 9 is high while current location equals goal location
// R7 - bit 8 is high while current speed equals goal speed
// R8 - bit 7 latches on arrival edge; reading clears it and its interrupt share
// R9 - bit 6 latches a stall halt; reading clears it and releases the halt
// R10 - bit 5 is high while a right switch halt is active
// R11 - bit 4 is high while a left switch halt is active
// R12 - hold mode or a move away from the switch removes the switch halt
// R13 - in gentle halt mode the switch halt stays until deceleration ends
// R14 - disabling a switch halt clears its flag and motion continues
// R15 - interrupt is the OR of bits 7, 6, 5 and 4
// R16 - bit 3 latches a completed right capture, cleared by reading
// R17 - bit 2 latches a completed left capture, cleared by reading
// R18 - bits 1 and 0 show live right and left switch levels
// R19 - enabled left switch stops the motor; motion resumes on release
// R20 - a read clears only sticky bits it returned set; new events survive
package rss_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int POS_W = 32;
  localparam int SPD_W = 24;
  localparam int STAT_W = 14;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h4;
  // status bit positions
  localparam int B_STALL_LVL = 13;
  localparam int B_REVERSED = 12;
  localparam int B_STANDSTILL = 11;
  localparam int B_SPEED_ZERO = 10;
  localparam int B_LOC_HIT = 9;
  localparam int B_SPD_HIT = 8;
  localparam int B_ARRIVAL = 7;
  localparam int B_STALL_HALT = 6;
  localparam int B_HALT_R = 5;
  localparam int B_HALT_L = 4;
  localparam int B_CAP_R = 3;
  localparam int B_CAP_L = 2;
  localparam int B_SW_R = 1;
  localparam int B_SW_L = 0;
  // config bit positions
  localparam int C_STOP_L_EN = 0;
  localparam int C_STOP_R_EN = 1;
  localparam int C_HALT_ON_STALL = 2;
  localparam int C_GENTLE_HALT = 3;
  localparam int C_STALL_CFG = 4;
  localparam int CFG_W = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
  localparam logic [STAT_W-1:0] STICKY_MASK = 14'h10cc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : rss_pkg

// ### rtl/rss_status.sv
// ramp and reference switch status register with axi4-lite access
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rss_status
  import rss_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // ramp generator state
  input wire logic stall_detect_level,
  input wire logic standstill_delay,
  input wire logic ramp_reversed,
  input wire logic hold_mode,
  input wire logic move_dir_right,
  input wire logic signed [SPD_W-1:0] current_speed,
  input wire logic signed [SPD_W-1:0] goal_speed,
  input wire logic signed [POS_W-1:0] current_location,
  input wire logic signed [POS_W-1:0] goal_location,
  // capture completion pulses
  input wire logic capture_r_done,
  input wire logic capture_l_done,
  // reference switch pins, active high
  input wire logic switch_r_pin,
  input wire logic switch_l_pin,
  // outputs to the ramp generator and host
  output logic motion_halt,
  output logic interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // switch synchronisers
  logic [1:0] sw_r_sync_r;
  logic [1:0] sw_l_sync_r;
  logic sw_r;
  logic sw_l;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_r_sync_r <= 2'h0;
      sw_l_sync_r <= 2'h0;
    end else if (ce) begin
      sw_r_sync_r <= {sw_r_sync_r[0], switch_r_pin};
      sw_l_sync_r <= {sw_l_sync_r[0], switch_l_pin};
    end
  end

  assign sw_r = sw_r_sync_r[1];
  assign sw_l = sw_l_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // configuration register
  logic [CFG_W-1:0] cfg_r;
  logic stop_l_en;
  logic stop_r_en;
  logic halt_on_stall_enable;
  logic gentle;
  logic stall_cfg;

  assign stop_l_en = cfg_r[C_STOP_L_EN];
  assign stop_r_en = cfg_r[C_STOP_R_EN];
  assign halt_on_stall_enable = cfg_r[C_HALT_ON_STALL];
  assign gentle = cfg_r[C_GENTLE_HALT];
  assign stall_cfg = cfg_r[C_STALL_CFG];

  ////////////////////////////////////////////////////////////////////////////
  // live conditions
  logic loc_hit;
  logic spd_hit;
  logic spd_zero;
  logic loc_hit_prev_r;
  logic stall_live;

  assign loc_hit = (current_location == goal_location);
  assign spd_hit = (current_speed == goal_speed);
  assign spd_zero = (current_speed == '0);
  assign stall_live = stall_detect_level & stall_cfg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loc_hit_prev_r <= 1'b0;
    end else if (ce) begin
      loc_hit_prev_r <= loc_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi handshake state
  logic aw_got_r;
  logic w_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [DATA_W-1:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_take;
  logic w_take;
  logic wr_do;
  logic rd_take;
  logic aw_got_nxt;
  logic w_got_nxt;
  logic bvalid_nxt;
  logic rvalid_nxt;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_do = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign aw_got_nxt = (aw_got_r & ~wr_do) | aw_take;
  assign w_got_nxt = (w_got_r & ~wr_do) | w_take;
  assign bvalid_nxt = wr_do | (s_axi_bvalid & ~s_axi_bready);
  assign rvalid_nxt = rd_take | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      s_axi_awready <= ~aw_got_nxt;
      s_axi_wready <= ~w_got_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (wr_do) begin
        s_axi_bresp <= (aw_addr_r == OFS_STATUS || aw_addr_r == OFS_CONFIG) ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

  // config write, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= CFG_RESET;
    end else if (ce && wr_do && aw_addr_r == OFS_CONFIG && w_strb_r[0]) begin
      cfg_r <= w_data_r[CFG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // switch halt conditions
  logic halt_r_r;
  logic halt_l_r;
  logic decel_r;
  logic decel_l;

  assign decel_r = gentle & (current_speed > 0);
  assign decel_l = gentle & (current_speed < 0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_r_r <= 1'b0;
    end else if (ce) begin
      if (!stop_r_en) begin
        halt_r_r <= 1'b0; // see R14
      end else if (sw_r & move_dir_right & ~hold_mode) begin
        halt_r_r <= 1'b1; // see R10
      end else if (!decel_r) begin
        halt_r_r <= 1'b0; // see R12, see R13
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_l_r <= 1'b0;
    end else if (ce) begin
      if (!stop_l_en) begin
        halt_l_r <= 1'b0; // see R14
      end else if (sw_l & ~move_dir_right & ~hold_mode) begin
        halt_l_r <= 1'b1; // see R11, see R19
      end else if (!decel_l) begin
        halt_l_r <= 1'b0; // see R12, see R13, see R19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky events, set wins over read clear
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] clr;
  logic reversed_r;
  logic arrival_r;
  logic stall_halt_r;
  logic cap_r_r;
  logic cap_l_r;
  logic arrival_set;
  logic stall_set;
  logic rd_status;

  assign rd_status = rd_take & (s_axi_araddr == OFS_STATUS);
  assign clr = rd_status ? (status & STICKY_MASK) : '0; // see R20
  assign arrival_set = loc_hit & ~loc_hit_prev_r;
  assign stall_set = stall_live & halt_on_stall_enable & ~spd_zero;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reversed_r <= 1'b0;
      arrival_r <= 1'b0;
      stall_halt_r <= 1'b0;
      cap_r_r <= 1'b0;
      cap_l_r <= 1'b0;
    end else if (ce) begin
      reversed_r <= ramp_reversed | (reversed_r & ~clr[B_REVERSED]); // see R3
      arrival_r <= arrival_set | (arrival_r & ~clr[B_ARRIVAL]); // see R8
      stall_halt_r <= stall_set | (stall_halt_r & ~clr[B_STALL_HALT]); // see R9
      cap_r_r <= capture_r_done | (cap_r_r & ~clr[B_CAP_R]); // see R16
      cap_l_r <= capture_l_done | (cap_l_r & ~clr[B_CAP_L]); // see R17
    end
  end

  always_comb begin
    status = '0;
    status[B_STALL_LVL] = stall_live; // see R1
    status[B_REVERSED] = reversed_r;
    status[B_STANDSTILL] = standstill_delay; // see R4
    status[B_SPEED_ZERO] = spd_zero; // see R5
    status[B_LOC_HIT] = loc_hit; // see R6
    status[B_SPD_HIT] = spd_hit; // see R7
    status[B_ARRIVAL] = arrival_r;
    status[B_STALL_HALT] = stall_halt_r;
    status[B_HALT_R] = halt_r_r;
    status[B_HALT_L] = halt_l_r;
    status[B_CAP_R] = cap_r_r;
    status[B_CAP_L] = cap_l_r;
    status[B_SW_R] = sw_r; // see R18
    status[B_SW_L] = sw_l; // see R18
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (rd_take) begin
        if (s_axi_araddr == OFS_STATUS) begin
          s_axi_rdata <= {{(DATA_W-STAT_W){1'b0}}, status};
          s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_araddr == OFS_CONFIG) begin
          s_axi_rdata <= {{(DATA_W-CFG_W){1'b0}}, cfg_r};
          s_axi_rresp <= RESP_OKAY;
        end else begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_DECERR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halt request and interrupt
  logic halt_nxt;
  logic irq_nxt;

  assign halt_nxt = halt_r_r | halt_l_r | stall_halt_r; // see R9, see R19
  assign irq_nxt = arrival_r | stall_halt_r | halt_r_r | halt_l_r; // see R15

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motion_halt <= 1'b0;
      interrupt <= 1'b0;
    end else if (ce) begin
      motion_halt <= halt_nxt;
      interrupt <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stall_live_read: assert property (ce && rd_status |=> ce |-> s_axi_rdata[B_STALL_LVL] == $past(stall_live)) // see R1
    else $error("stall level bit wrong in read data");
  a_reverse_latch: assert property (ce && ramp_reversed ##1 ce |-> status[B_REVERSED]) // see R3
    else $error("reversal not latched");
  a_speed_zero_read: assert property (ce && rd_status |=> s_axi_rdata[B_SPEED_ZERO] == ($past(current_speed) == 0)) // see R5
    else $error("zero speed bit wrong");
  a_arrival_edge: assert property (ce && loc_hit && !loc_hit_prev_r |=> arrival_r) // see R8
    else $error("arrival not latched on match edge");
  a_arrival_clear: assert property (ce && rd_status && arrival_r && !arrival_set |=> !arrival_r) // see R8, see R20
    else $error("arrival not cleared by read");
  a_set_wins: assert property (ce && rd_status && stall_set |=> stall_halt_r) // see R20
    else $error("stall event lost during read clear");
  a_disable_clears: assert property (ce && !stop_r_en |=> !halt_r_r) // see R14
    else $error("right halt not cleared when disabled");
  a_gentle_hold: assert property (ce && halt_l_r && stop_l_en && gentle && current_speed < 0 |=> halt_l_r) // see R13
    else $error("left halt released during deceleration");
  a_left_halt_set: assert property (ce && sw_l && stop_l_en && !move_dir_right && !hold_mode // see R11, see R19
    |=> halt_l_r ##1 (!$past(ce) || motion_halt))
    else $error("left switch did not halt motion");
  a_irq_or: assert property (ce && (arrival_r || stall_halt_r || halt_r_r || halt_l_r) |=> interrupt) // see R15
    else $error("interrupt missing for pending event");
  a_cap_r_latch: assert property (ce && capture_r_done |=> cap_r_r) // see R16
    else $error("right capture not latched");
  a_cap_l_latch: assert property (ce && capture_l_done |=> cap_l_r) // see R17
    else $error("left capture not latched");
  a_irq_idle: assert property (ce && !(arrival_r || stall_halt_r || halt_r_r || halt_l_r) |=> !interrupt) // see R15
    else $error("interrupt raised with no pending event");
  a_right_halt_set: assert property (ce && sw_r && stop_r_en && move_dir_right && !hold_mode |=> halt_r_r) // see R10
    else $error("right switch did not raise halt");
  a_hold_release: assert property (ce && hold_mode && !(gentle && current_speed > 0) |=> !halt_r_r) // see R12
    else $error("right halt kept in hold mode");
  a_stall_halt_set: assert property (ce && stall_live && halt_on_stall_enable && !spd_zero |=> stall_halt_r) // see R9
    else $error("stall halt not latched");

endmodule : rss_status
`default_nettype wire

// ### tb/rss_host_model.sv
// axi4-lite host model issuing single reads and writes
`timescale 1ns/1ps
`default_nettype none
module rss_host_model
  import rss_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request and result
  input wire logic start,
  input wire logic wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdat,
  output logic done,
  output logic [33:0] result,
  // axi4-lite master side
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, done, result} = '0;
  end
  // hold each channel until its own handshake edge
  always @(posedge aclk) begin
    done <= 1'b0;
    if (!aresetn) begin
      {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    end else if (start) begin
      if (wr) begin
        awaddr <= addr;
        wdata <= wdat;
        wstrb <= 4'hf;
        {awvalid, wvalid, bready} <= 3'h7;
      end else begin
        araddr <= addr;
        {arvalid, rready} <= 2'h3;
      end
    end else begin
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        done <= 1'b1;
        result <= {bresp, 32'h0};
      end
      if (rvalid && rready) begin
        rready <= 1'b0;
        done <= 1'b1;
        result <= {rresp, rdata};
      end
    end
  end
endmodule : rss_host_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the ramp and switch status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rss_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic start = 1'b0;
  logic wr = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wdat = 32'h0;
  logic done;
  logic [33:0] result;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic stall = 1'b0, still = 1'b0, rev = 1'b0, hold = 1'b0, dir_r = 1'b0;
  logic cap_r = 1'b0, cap_l = 1'b0, sw_r = 1'b0, sw_l = 1'b0;
  logic signed [SPD_W-1:0] spd = 24'h0, gspd = 24'h0;
  logic signed [POS_W-1:0] loc = 32'h0, gloc = 32'h1;
  logic halt, irq;
  logic ce = 1'b1;
  logic [33:0] exp_q[$];
  int bad_count = 0;
  int samples_checked = 0;
  int seed = 32'h2e782534;
  logic [31:0] rs;

  always #12.5 aclk = ~aclk;

  rss_host_model u_host (.aclk(aclk), .aresetn(aresetn), .start(start), .wr(wr), .addr(addr), .wdat(wdat),
    .done(done), .result(result), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  rss_status u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .stall_detect_level(stall),
    .standstill_delay(still), .ramp_reversed(rev), .hold_mode(hold), .move_dir_right(dir_r),
    .current_speed(spd), .goal_speed(gspd), .current_location(loc), .goal_location(gloc),
    .capture_r_done(cap_r), .capture_l_done(cap_l), .switch_r_pin(sw_r), .switch_l_pin(sw_l),
    .motion_halt(halt), .interrupt(irq));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] b(input int i);
    return 32'h1 << i;
  endfunction : b

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic stop_test();
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // sel 1 watches the halt request, sel 0 the interrupt
  task automatic lvl(input logic sel, input logic exp);
    @(negedge aclk);
    cmp({33'h0, sel ? halt : irq}, {33'h0, exp});
    @(posedge aclk);
  endtask : lvl

  task automatic op(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [33:0] e);
    int n;
    exp_q.push_back(e);
    @(posedge aclk);
    start <= 1'b1;
    wr <= w;
    addr <= a;
    wdat <= d;
    @(posedge aclk);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (done !== 1'b1 && n < 200);
    if (done !== 1'b1) bad_count++;
    @(posedge aclk);
  endtask : op

  task automatic rd_stat(input logic [31:0] e);
    op(1'b0, OFS_STATUS, 32'h0, {RESP_OKAY, e});
  endtask : rd_stat

  // result monitor takes the oldest note
  always @(posedge aclk) begin
    if (done === 1'b1) cmp(result, exp_q.pop_front());
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    loc = $random(seed);
    gloc = loc + 32'sh1;
    rs = $random(seed);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    op(1'b1, OFS_CONFIG, 32'h17, {RESP_OKAY, 32'h0});
    op(1'b0, OFS_CONFIG, 32'h0, {RESP_OKAY, 32'h17});
    op(1'b0, 4'h8, 32'h0, {RESP_DECERR, 32'h0});
    op(1'b1, 4'hc, 32'h5, {RESP_DECERR, 32'h0});
    op(1'b1, OFS_STATUS, 32'h3fff, {RESP_OKAY, 32'h0});
    rd_stat(b(10) | b(8));
    gloc <= loc;
    still <= 1'b1;
    stall <= 1'b1;
    tick(3);
    lvl(1'b0, 1'b1);
    rd_stat(b(13) | b(11) | b(10) | b(9) | b(8) | b(7));
    rd_stat(b(13) | b(11) | b(10) | b(9) | b(8));
    lvl(1'b0, 1'b0);
    rev <= 1'b1;
    cap_r <= 1'b1;
    cap_l <= 1'b1;
    tick(1);
    {rev, cap_r, cap_l} <= 3'h0;
    rd_stat(b(13) | b(12) | b(11) | b(10) | b(9) | b(8) | b(3) | b(2));
    rd_stat(b(13) | b(11) | b(10) | b(9) | b(8));
    ce <= 1'b0;
    still <= 1'b0;
    spd <= $signed({1'b0, rs[22:0] | 23'h1});
    gspd <= $signed({1'b0, rs[22:0] | 23'h1});
    tick(3);
    lvl(1'b1, 1'b0);
    ce <= 1'b1;
    tick(3);
    lvl(1'b1, 1'b1);
    stall <= 1'b0;
    rd_stat(b(9) | b(8) | b(6));
    tick(2);
    lvl(1'b1, 1'b0);
    dir_r <= 1'b1;
    sw_r <= 1'b1;
    tick(5);
    rd_stat(b(9) | b(8) | b(5) | b(1));
    hold <= 1'b1;
    tick(3);
    rd_stat(b(9) | b(8) | b(1));
    {hold, sw_r, dir_r} <= 3'h0;
    sw_l <= 1'b1;
    tick(5);
    rd_stat(b(9) | b(8) | b(4) | b(0));
    lvl(1'b1, 1'b1);
    sw_l <= 1'b0;
    tick(5);
    rd_stat(b(9) | b(8));
    lvl(1'b1, 1'b0);
    sw_l <= 1'b1;
    tick(5);
    op(1'b1, OFS_CONFIG, 32'h16, {RESP_OKAY, 32'h0});
    rd_stat(b(9) | b(8) | b(0));
    lvl(1'b1, 1'b0);
    op(1'b1, OFS_CONFIG, 32'h1f, {RESP_OKAY, 32'h0});
    spd <= -spd;
    gspd <= -gspd;
    tick(5);
    hold <= 1'b1;
    tick(3);
    rd_stat(b(9) | b(8) | b(4) | b(0));
    spd <= 24'h0;
    gspd <= 24'h0;
    tick(3);
    rd_stat(b(10) | b(9) | b(8) | b(0));
    stop_test();
  end

  initial begin
    #100000;
    bad_count++;
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
